// ### icc_pkg.sv
//Function
//- idle halt bit stops channel in idle
//- time base select picks counted clock
//- rate field sets captures per interrupt
//- hardware sets read-only overflow flag
//- buffer-not-empty bit tracks stored values
//- mode 000 turns channel off
//- mode 001 captures every edge, rate ignored
//- mode 010 captures falling edges
//- mode 100 captures every fourth rise
//- mode 101 captures every sixteenth rise
//- mode 111 rising edge wake interrupt only
//- mode 110 leaves channel disabled
//- unimplemented control bits read zero
//- capture stores current 16-bit counter
//- buffer holds four values in order
//- reading last value clears not-empty bit
package icc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
    localparam logic [3:0]  ADDR_BUFFER    = 4'h1;
    localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h2;
    localparam logic [3:0]  ADDR_IRQ_MASK  = 4'h3;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK  = 16'h3C67;
    localparam logic [1:0]  IRQ_RESET      = 2'h0;
    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_IDLE_HALT   = 13;
    localparam int POS_TBASE_LO    = 10;
    localparam int POS_RATE_LO     = 5;
    localparam int POS_OVERFLOW    = 4;
    localparam int POS_NOT_EMPTY   = 3;
    localparam int POS_MODE_LO     = 0;
    localparam int IRQ_CAPTURE     = 0;
    localparam int IRQ_OVERFLOW    = 1;
    // ****************************************
    // modes and time bases
    // ****************************************
    localparam logic [2:0] MODE_OFF     = 3'h0;
    localparam logic [2:0] MODE_EDGE    = 3'h1;
    localparam logic [2:0] MODE_FALL_A  = 3'h2;
    localparam logic [2:0] MODE_FALL_B  = 3'h3;
    localparam logic [2:0] MODE_PRE4    = 3'h4;
    localparam logic [2:0] MODE_PRE16   = 3'h5;
    localparam logic [2:0] MODE_UNUSED  = 3'h6;
    localparam logic [2:0] MODE_WAKE    = 3'h7;
    localparam logic [2:0] TB_TIMER3    = 3'h0;
    localparam logic [2:0] TB_TIMER2    = 3'h1;
    localparam logic [2:0] TB_TIMER4    = 3'h2;
    localparam logic [2:0] TB_TIMER5    = 3'h3;
    localparam logic [2:0] TB_TIMER1    = 3'h4;
    localparam logic [2:0] TB_SYSCLK    = 3'h7;
    localparam int         FIFO_DEPTH   = 4;
    localparam logic [3:0] PRE4_LAST    = 4'h3;
    localparam logic [3:0] PRE16_LAST   = 4'hF;
endpackage : icc_pkg

// ### icc_channel.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
module icc_channel
(
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_capture_input_pin,
    input  wire logic [4:0]  i_timer_tick,
    input  wire logic        i_cpu_idle,
    input  wire logic        i_cpu_sleep,
    output logic             o_irq,
    output logic             o_wake_irq
);
    // ****************************************
    // control register
    // ****************************************
    logic [15:0] control;
    logic [2:0]  mode;
    logic [2:0]  tbase;
    logic [1:0]  rate;
    logic        idle_halt;
    logic        overflow;
    logic [2:0]  count;
    logic        ctl_wr;
    logic        mode_wr;
    assign ctl_wr    = i_wr && (i_addr == icc_pkg::ADDR_CONTROL);
    assign mode_wr   = ctl_wr && (i_wdata[icc_pkg::POS_MODE_LO +: 3] != mode);
    assign mode      = control[icc_pkg::POS_MODE_LO +: 3];
    assign tbase     = control[icc_pkg::POS_TBASE_LO +: 3];
    assign rate      = control[icc_pkg::POS_RATE_LO +: 2];
    assign idle_halt = control[icc_pkg::POS_IDLE_HALT];

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            control <= icc_pkg::CONTROL_RESET;
        else if (ctl_wr)
            control <= i_wdata & icc_pkg::CONTROL_WMASK;
    end

    // ****************************************
    // input synchroniser and edge detect
    // ****************************************
    logic [2:0] pin_sync;
    logic       rise;
    logic       fall;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pin_sync <= 3'h0;
        else
            pin_sync <= {pin_sync[1:0], i_capture_input_pin};
    end
    assign rise = pin_sync[1] && !pin_sync[2];
    assign fall = !pin_sync[1] && pin_sync[2];

    // ****************************************
    // time base and counter
    // ****************************************
    logic        running;
    logic        tick;
    logic [15:0] counter;
    // reserved selections count nothing rather than guessing a source
    always_comb
    begin
        case (tbase)
            icc_pkg::TB_TIMER3: tick = i_timer_tick[2];
            icc_pkg::TB_TIMER2: tick = i_timer_tick[1];
            icc_pkg::TB_TIMER4: tick = i_timer_tick[3];
            icc_pkg::TB_TIMER5: tick = i_timer_tick[4];
            icc_pkg::TB_TIMER1: tick = i_timer_tick[0];
            icc_pkg::TB_SYSCLK: tick = 1'b1;
            default:            tick = 1'b0;
        endcase
    end
    // modes off, unused and wake do no capturing
    assign running = (mode != icc_pkg::MODE_OFF) && (mode != icc_pkg::MODE_UNUSED)
                     && (mode != icc_pkg::MODE_WAKE)
                     && !(idle_halt && i_cpu_idle);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            counter <= 16'h0000;
        else if (running && tick)
            counter <= counter + 16'h0001;
    end

    // ****************************************
    // capture event decode
    // ****************************************
    logic [3:0] pre_cnt;
    logic       pre_hit;
    logic       event_cap;
    assign pre_hit = (mode == icc_pkg::MODE_PRE4) ? (pre_cnt == icc_pkg::PRE4_LAST)
                                                  : (pre_cnt == icc_pkg::PRE16_LAST);
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pre_cnt <= 4'h0;
        else if (mode_wr || !running)
            pre_cnt <= 4'h0;
        else if (rise && ((mode == icc_pkg::MODE_PRE4) || (mode == icc_pkg::MODE_PRE16)))
            pre_cnt <= pre_hit ? 4'h0 : pre_cnt + 4'h1;
    end

    always_comb
    begin
        event_cap = 1'b0;
        if (running)
        begin
            case (mode)
                icc_pkg::MODE_EDGE:   event_cap = rise || fall;
                icc_pkg::MODE_FALL_A: event_cap = fall;
                icc_pkg::MODE_FALL_B: event_cap = fall;
                icc_pkg::MODE_PRE4:   event_cap = rise && pre_hit;
                icc_pkg::MODE_PRE16:  event_cap = rise && pre_hit;
                default:              event_cap = 1'b0;
            endcase
        end
    end

    // ****************************************
    // capture fifo
    // ****************************************
    logic [15:0] fifo_mem [icc_pkg::FIFO_DEPTH];
    logic [1:0]  wr_ptr;
    logic [1:0]  rd_ptr;
    logic        full;
    logic        empty;
    logic        buf_rd;
    logic        do_write;
    assign full     = (count == 3'(icc_pkg::FIFO_DEPTH));
    assign empty    = (count == 3'h0);
    assign buf_rd   = i_rd && (i_addr == icc_pkg::ADDR_BUFFER) && !empty;
    // a capture into a full buffer is dropped unless a read pops a value in the same cycle; the old values are kept
    assign do_write = event_cap && (!full || buf_rd);

    always_ff @(posedge i_clk)
    begin
        if (do_write)
            fifo_mem[wr_ptr] <= counter;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count  <= 3'h0;
        end
        else
        begin
            if (do_write)
                wr_ptr <= wr_ptr + 2'h1;
            if (buf_rd)
                rd_ptr <= rd_ptr + 2'h1;
            count <= count + {2'h0, do_write} - {2'h0, buf_rd};
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            overflow <= 1'b0;
        else if (event_cap && full && !buf_rd)
            overflow <= 1'b1;
        // clear on the edge that pops the last value, so a back-to-back control read never sees it stale
        else if (empty || (buf_rd && !do_write && (count == 3'h1)))
            overflow <= 1'b0;
    end

    // ****************************************
    // interrupt rate counter
    // ****************************************
    logic [1:0] rate_cnt;
    logic       cap_irq_evt;
    assign cap_irq_evt = event_cap && ((mode == icc_pkg::MODE_EDGE) || (rate_cnt == rate));
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rate_cnt <= 2'h0;
        else if (mode_wr || !running)
            rate_cnt <= 2'h0;
        else if (event_cap && (mode != icc_pkg::MODE_EDGE))
            rate_cnt <= (rate_cnt == rate) ? 2'h0 : rate_cnt + 2'h1;
    end

    // ****************************************
    // interrupt status, mask and wake
    // ****************************************
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] irq_set;
    logic       stat_rd;
    logic       wake_evt;
    assign irq_set  = {event_cap && full && !buf_rd, cap_irq_evt};
    assign stat_rd  = i_rd && (i_addr == icc_pkg::ADDR_IRQ_STAT);
    assign wake_evt = (mode == icc_pkg::MODE_WAKE) && (i_cpu_sleep || i_cpu_idle) && rise;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            irq_stat <= icc_pkg::IRQ_RESET;
        else if (stat_rd)
            irq_stat <= irq_set; // set wins over read clear
        else
            irq_stat <= irq_stat | irq_set;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            irq_mask <= icc_pkg::IRQ_RESET;
        else if (i_wr && (i_addr == icc_pkg::ADDR_IRQ_MASK))
            irq_mask <= i_wdata[1:0];
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq      <= 1'b0;
            o_wake_irq <= 1'b0;
        end
        else
        begin
            o_irq      <= |(irq_mask & (stat_rd ? irq_set : (irq_stat | irq_set)));
            o_wake_irq <= wake_evt;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    logic [15:0] ctl_view;
    always_comb
    begin
        ctl_view = control;
        ctl_view[icc_pkg::POS_OVERFLOW]  = overflow;
        ctl_view[icc_pkg::POS_NOT_EMPTY] = !empty;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 16'h0000;
        else if (i_rd)
        begin
            case (i_addr)
                icc_pkg::ADDR_CONTROL:  o_rdata <= ctl_view;
                icc_pkg::ADDR_BUFFER:   o_rdata <= empty ? 16'h0000 : fifo_mem[rd_ptr];
                icc_pkg::ADDR_IRQ_STAT: o_rdata <= {14'h0000, irq_stat};
                icc_pkg::ADDR_IRQ_MASK: o_rdata <= {14'h0000, irq_mask};
                default:                o_rdata <= 16'h0000;
            endcase
        end
        else
            o_rdata <= 16'h0000;
    end
endmodule : icc_channel

// ### icc_pin_model.sv
`timescale 1ns/100ps
module icc_pin_model
(
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [4:0] i_count,
    output logic            o_pin,
    output logic            o_busy
);
    // ****************************************
    // pulse train, 4 clocks high, 4 low
    // ****************************************
    // pin rests low between trains, as with a pull-down
    initial
    begin
        o_pin  = 1'b0;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_go)
            begin
                o_busy <= 1'b1;
                repeat (i_count)
                begin
                    o_pin <= 1'b1;
                    repeat (4) @(posedge i_clk);
                    o_pin <= 1'b0;
                    repeat (4) @(posedge i_clk);
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule : icc_pin_model

// ### icc_channel_chk.sv
`timescale 1ns/100ps
module icc_channel_chk
(
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] o_rdata,
    input  wire logic        i_cpu_idle,
    input  wire logic        i_cpu_sleep,
    input  wire logic        o_irq,
    input  wire logic        o_wake_irq
);
    // ****************************************
    // port rules
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    ctl_unimpl_a: assert property (
        $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata[15:14] == 2'h0 && o_rdata[9:7] == 3'h0)
        else $error("unimplemented control bits set");
    unmapped_a: assert property ($past(i_rd) && $past(i_addr) > 4'h3 |-> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    ov_needs_data_a: assert property (
        $past(i_rd) && $past(i_addr) == 4'h0 && o_rdata[4] |-> o_rdata[3])
        else $error("overflow with empty buffer");
    ctl_readback_a: assert property (
        (i_wr && i_addr == 4'h0) ##1 (i_rd && i_addr == 4'h0)
        |=> (o_rdata & icc_pkg::CONTROL_WMASK) == ($past(i_wdata, 2) & icc_pkg::CONTROL_WMASK))
        else $error("control readback differs");
    wake_pulse_a: assert property (o_wake_irq |=> !o_wake_irq)
        else $error("wake pulse too long");
    wake_state_a: assert property (o_wake_irq |-> $past(i_cpu_sleep || i_cpu_idle))
        else $error("wake pulse while running");
    irq_mask_a: assert property (i_wr && i_addr == 4'h3 && i_wdata[1:0] == 2'h0 |=> ##1 !o_irq)
        else $error("masked interrupt raised");
endmodule : icc_channel_chk

bind icc_channel icc_channel_chk u_chk (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
                                        .i_cpu_idle, .i_cpu_sleep, .o_irq, .o_wake_irq);

// ### icc_tb.sv
`timescale 1ns/100ps
module testbench;
    logic        i_clk;
    logic        i_reset_n;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [15:0] o_rdata;
    logic        pin;
    logic [4:0]  i_timer_tick;
    logic        i_cpu_idle;
    logic        i_cpu_sleep;
    logic        o_irq;
    logic        o_wake_irq;
    logic        go;
    logic [4:0]  n_pulse;
    logic        busy;
    logic [15:0] d;
    int          n_errors;
    int          tests_run;
    int          n_wake = 0;

    icc_channel u_dut (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
                       .i_capture_input_pin(pin), .i_timer_tick, .i_cpu_idle, .i_cpu_sleep, .o_irq, .o_wake_irq);
    icc_pin_model u_pin (.i_clk, .i_go(go), .i_count(n_pulse), .o_pin(pin), .o_busy(busy));

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(negedge i_clk)
        if (o_wake_irq === 1'b1) n_wake++;

    // ****************************************
    // shared tasks
    // ****************************************
    task stop_test;
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] v);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [15:0] v);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        @(posedge i_clk);
    endtask : rd

    task pulses(input logic [4:0] n);
        int t;
        n_pulse <= n;
        go      <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        t = 0;
        #1;
        while (busy !== 1'b0 && t < 400)
        begin
            @(posedge i_clk);
            #1 t++;
        end
        if (t == 400)
        begin
            n_errors++;
            stop_test();
        end
        // synchroniser delay before the last edge is stored
        repeat (6) @(posedge i_clk);
    endtask : pulses

    task drain(input int pops, input logic [15:0] diff, input logic ov);
        logic [15:0] v [8];
        int          k;
        k = 0;
        rd(4'h0, d);
        chk(16'(d[4]), 16'(ov));
        while (d[3] === 1'b1 && k < 8)
        begin
            rd(4'h1, v[k]);
            k++;
            rd(4'h0, d);
        end
        chk(16'(k), 16'(pops));
        if (k > 1) chk(v[1] - v[0], diff);
        chk(16'(d[4]), 16'h0000);
    endtask : drain

    task run(input logic [15:0] ctl, input logic [4:0] n, input int pops, input logic [15:0] diff, input logic ov);
        wr(4'h0, ctl);
        pulses(n);
        drain(pops, diff, ov);
        wr(4'h0, 16'h0000);
        // let an edge pass so a following write never re-raises the strobe in this step
        @(posedge i_clk);
    endtask : run

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rd(4'h0, d);
        chk(d, icc_pkg::CONTROL_RESET);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, d);
        chk(d, icc_pkg::CONTROL_WMASK);
        wr(4'h0, 16'h0000);
        rd(4'hF, d);
        chk(d, 16'h0000);
    endtask : t_regs

    // timer3 ticks every clock, timer1 never
    task t_modes;
        run(16'h1C02, 2, 2, 16'h0008, 1'b0);
        run(16'h1C03, 2, 2, 16'h0008, 1'b0);
        run(16'h1C01, 1, 2, 16'h0004, 1'b0);
        run(16'h1C04, 4, 1, 16'h0000, 1'b0);
        run(16'h1C05, 16, 1, 16'h0000, 1'b0);
        run(16'h1C00, 2, 0, 16'h0000, 1'b0);
        run(16'h1C06, 2, 0, 16'h0000, 1'b0);
        run(16'h0002, 2, 2, 16'h0008, 1'b0);
        run(16'h1002, 2, 2, 16'h0000, 1'b0);
        // reserved selections must count nothing even with every timer ticking
        i_timer_tick <= 5'h1F;
        run(16'h1402, 2, 2, 16'h0000, 1'b0);
        run(16'h1802, 2, 2, 16'h0000, 1'b0);
        // only timer2 and timer5 tick here
        i_timer_tick <= 5'h12;
        run(16'h0402, 2, 2, 16'h0008, 1'b0);
        run(16'h0C02, 2, 2, 16'h0008, 1'b0);
        run(16'h0802, 2, 2, 16'h0000, 1'b0);
        i_timer_tick <= 5'h04;
        run(16'h1C02, 5, 4, 16'h0008, 1'b1);
    endtask : t_modes

    task t_rate;
        wr(4'h3, 16'h0001);
        // sticky bits left by the mode runs: capture and overflow; the read clears them
        rd(4'h2, d);
        chk(d, 16'h0003);
        wr(4'h0, 16'h1C62);
        pulses(3);
        #1 chk(16'(o_irq), 16'h0000);
        pulses(1);
        #1 chk(16'(o_irq), 16'h0001);
        @(posedge i_clk);
        rd(4'h2, d);
        chk(16'(d[0]), 16'h0001);
        #1 chk(16'(o_irq), 16'h0000);
        @(posedge i_clk);
        drain(4, 16'h0008, 1'b0);
        wr(4'h0, 16'h0000);
        @(posedge i_clk);
        wr(4'h3, 16'h0000);
        @(posedge i_clk);
    endtask : t_rate

    task t_power;
        int base;
        i_cpu_idle <= 1'b1;
        run(16'h3C02, 2, 0, 16'h0000, 1'b0);
        run(16'h1C02, 2, 2, 16'h0008, 1'b0);
        i_cpu_idle  <= 1'b0;
        i_cpu_sleep <= 1'b1;
        base = n_wake;
        run(16'h0007, 3, 0, 16'h0000, 1'b0);
        chk(16'(n_wake - base), 16'h0003);
        i_cpu_sleep <= 1'b0;
    endtask : t_power

    initial
    begin
        i_reset_n    = 1'b0;
        i_addr       = 4'h0;
        i_wdata      = 16'h0000;
        i_wr         = 1'b0;
        i_rd         = 1'b0;
        i_timer_tick = 5'h04;
        i_cpu_idle   = 1'b0;
        i_cpu_sleep  = 1'b0;
        go           = 1'b0;
        n_pulse      = 5'h00;
        n_errors     = 0;
        tests_run    = 0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_modes();
        t_rate();
        t_power();
        stop_test();
    end
endmodule : testbench
